// file: design/abc_pkg.sv
// Shared constants and types for the black-level calibration link
package abc_pkg;
   // Start-of-line method codes
   localparam logic [1:0] MARK_REG     = 2'h0;
   localparam logic [1:0] MARK_PIN_POS = 2'h2;
   localparam logic [1:0] MARK_PIN_NEG = 2'h3;
   // Resolution codes
   localparam logic [1:0] RES_16 = 2'h0;
   localparam logic [1:0] RES_12 = 2'h1;
   localparam logic [1:0] RES_10 = 2'h2;
   localparam logic [1:0] RES_8  = 2'h3;
   // Field widths and reset values
   localparam int          DEL_W      = 7;
   localparam int          BPIX_W     = 10;
   localparam int          ITER_W     = 3;
   localparam int          RATIO_W    = 4;
   localparam logic [7:0]  TARGET_RST = 8'h00;
   localparam logic [7:0]  DAC_RST    = 8'h80;
   // Coarse iteration minimum master clocks, per channel count
   localparam logic [5:0]  CMIN_MONO  = 6'h0b;
   localparam logic [5:0]  CMIN_TWO   = 6'h0b;
   localparam logic [5:0]  CMIN_THREE = 6'h0c;
   // Controller register byte offsets
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_TARGET  = 8'h04;
   localparam logic [7:0]  REG_TIMING  = 8'h08;
   localparam logic [7:0]  REG_CMD     = 8'h0c;
   localparam logic [7:0]  REG_STATUS  = 8'h10;
   localparam logic [7:0]  REG_PIXEL   = 8'h14;
   localparam logic [7:0]  REG_RESULT  = 8'h18;
   // Calibration states
   typedef enum logic [2:0] {
      ST_IDLE, ST_DELAY, ST_COARSE, ST_FINE, ST_APPLY
   } abc_state_t;
endpackage

// file: design/abc_if.sv
// Link between the calibration controller and the calibration device
`timescale 1ns/10ps
interface abc_if;
   // Configuration set by the controller
   logic [1:0]  line_marker_source;
   logic        line_marker_bit;
   logic        sequence_begin_cmd;
   logic [1:0]  resolution;
   logic [1:0]  channel_count;
   logic [3:0]  mclk_per_sample;
   logic [7:0]  red_black_target;
   logic [7:0]  green_black_target;
   logic [7:0]  blue_black_target;
   logic [6:0]  dummy_pixel_delay;
   logic [9:0]  black_pixel_count;
   logic [2:0]  coarse_iteration_limit;
   logic        calib_status_on_output;
   // Line timing from the controller
   logic        output_enable_pin;
   logic        pixel_sample_strobe;
   logic [15:0] adc_code;
   logic [1:0]  adc_channel;
   // Results from the device
   logic [15:0] output_data_bus;
   logic        output_valid;
   logic        marker_taken;
   logic        calib_busy;
   logic [7:0]  offset_dac;
   modport device (
      input  line_marker_source, line_marker_bit, sequence_begin_cmd, resolution,
             channel_count, mclk_per_sample, red_black_target, green_black_target,
             blue_black_target, dummy_pixel_delay, black_pixel_count,
             coarse_iteration_limit, calib_status_on_output, output_enable_pin,
             pixel_sample_strobe, adc_code, adc_channel,
      output output_data_bus, output_valid, marker_taken, calib_busy, offset_dac
   );
   modport host (
      output line_marker_source, line_marker_bit, sequence_begin_cmd, resolution,
             channel_count, mclk_per_sample, red_black_target, green_black_target,
             blue_black_target, dummy_pixel_delay, black_pixel_count,
             coarse_iteration_limit, calib_status_on_output, output_enable_pin,
             pixel_sample_strobe, adc_code, adc_channel,
      input  output_data_bus, output_valid, marker_taken, calib_busy, offset_dac
   );
endinterface

// file: design/abc_apb_regs.sv
// APB slave register file for the calibration controller
`timescale 1ns/10ps
module abc_apb_regs (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Register contents
   output logic      [31:0] ctrl,
   output logic      [31:0] target,
   output logic      [31:0] timing,
   output logic             cmd_wr,
   output logic      [31:0] cmd_data,
   input  wire logic [31:0] status,
   input  wire logic [31:0] pixel,
   input  wire logic [31:0] result
);
   // Address decode
   wire        acc      = psel & penable & clk_en;
   wire        wr       = acc & pwrite;
   wire        hit_ctrl = paddr == abc_pkg::REG_CTRL;
   wire        hit_tgt  = paddr == abc_pkg::REG_TARGET;
   wire        hit_tim  = paddr == abc_pkg::REG_TIMING;
   wire        hit_cmd  = paddr == abc_pkg::REG_CMD;
   wire        hit_ro   = paddr == abc_pkg::REG_STATUS || paddr == abc_pkg::REG_PIXEL ||
                          paddr == abc_pkg::REG_RESULT;
   wire        mapped   = hit_ctrl | hit_tgt | hit_tim | hit_cmd | hit_ro;
   wire [31:0] rd_mux   = hit_ctrl ? ctrl :
                          hit_tgt ? target :
                          hit_tim ? timing :
                          paddr == abc_pkg::REG_STATUS ? status :
                          paddr == abc_pkg::REG_PIXEL ? pixel :
                          paddr == abc_pkg::REG_RESULT ? result : 32'h0;
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;
   assign prdata  = rd_mux;
   // Writable registers, command is a one-cycle strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl     <= 32'h0;
         target   <= {8'h0, {3{abc_pkg::TARGET_RST}}};
         timing   <= 32'h0;
         cmd_wr   <= 1'b0;
         cmd_data <= 32'h0;
      end else if (clk_en) begin
         cmd_wr <= wr & hit_cmd;
         if (wr & hit_ctrl) ctrl <= pwdata;
         if (wr & hit_tgt) target <= pwdata;
         if (wr & hit_tim) timing <= pwdata;
         if (wr & hit_cmd) cmd_data <= pwdata;
      end
   end
endmodule

// file: design/abc_host.sv
// Controller end: APB registers driving the calibration link
`timescale 1ns/10ps
module abc_host (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Link
   abc_if.host              lnk
);
   logic [31:0] ctrl;
   logic [31:0] target;
   logic [31:0] timing;
   logic        cmd_wr;
   logic [31:0] cmd_data;
   logic        mark_r;
   logic        seq_r;
   logic        pin_r;
   logic        strobe_r;
   logic [15:0] code_r;
   logic [1:0]  chan_r;
   logic [15:0] last_out;

   abc_apb_regs u_regs (
      .pclk     (pclk),
      .presetn  (presetn),
      .clk_en   (clk_en),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .ctrl     (ctrl),
      .target   (target),
      .timing   (timing),
      .cmd_wr   (cmd_wr),
      .cmd_data (cmd_data),
      .status   ({29'h0, lnk.calib_busy, lnk.marker_taken, lnk.output_valid}),
      .pixel    ({16'h0, last_out}),
      .result   ({24'h0, lnk.offset_dac})
   );

   // Configuration straight from registers, line signals from the command logic; software keeps low target bits zero
   assign lnk.line_marker_source     = ctrl[1:0];
   assign lnk.resolution             = ctrl[3:2];
   assign lnk.channel_count          = ctrl[5:4];
   assign lnk.mclk_per_sample        = ctrl[11:8];
   assign lnk.calib_status_on_output = ctrl[12];
   assign lnk.red_black_target       = target[7:0];
   assign lnk.green_black_target     = target[15:8];
   assign lnk.blue_black_target      = target[23:16];
   assign lnk.dummy_pixel_delay      = timing[6:0];
   assign lnk.black_pixel_count      = timing[17:8];
   assign lnk.coarse_iteration_limit = timing[26:24];
   assign lnk.line_marker_bit        = mark_r;
   assign lnk.sequence_begin_cmd     = seq_r;
   assign lnk.output_enable_pin      = pin_r;
   assign lnk.pixel_sample_strobe    = strobe_r;
   assign lnk.adc_code               = code_r;
   assign lnk.adc_channel            = chan_r;

   // Marker bit held until the device reports the marker taken; pixel feed
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mark_r   <= 1'b0;
         seq_r    <= 1'b0;
         pin_r    <= 1'b0;
         strobe_r <= 1'b0;
         code_r   <= 16'h0;
         chan_r   <= 2'h0;
         last_out <= 16'h0;
      end else if (clk_en) begin
         seq_r    <= cmd_wr & cmd_data[1];
         pin_r    <= cmd_wr ? cmd_data[2] : pin_r;
         strobe_r <= cmd_wr & cmd_data[3];
         if (cmd_wr & cmd_data[3]) code_r <= cmd_data[31:16];
         if (cmd_wr & cmd_data[3]) chan_r <= cmd_data[5:4];
         if (cmd_wr & cmd_data[0]) mark_r <= 1'b1;
         else if (lnk.marker_taken) mark_r <= 1'b0;
         if (lnk.output_valid) last_out <= lnk.output_data_bus;
      end
   end
endmodule

// file: design/abc_device.sv
// Device end: automatic black-level calibration engine
//
// Function
// - Subtract black average excess from image codes
// - Separate eight-bit target per colour channel
// - Sixteen-bit output compares target at bits 11:4
// - Twelve-bit arithmetic, target matches low byte
// - Ten-bit mode: software zeroes two target LSBs
// - Eight-bit mode: software zeroes four target LSBs
// - Coarse stage steps offset DAC per iteration
// - Fine stage removes residual offset digitally
// - Method 10/11 selects pin, rising/falling edge
// - Method 00 selects register marker
// - Pin pulse spans at least one clock edge
// - First edge after marker bit starts line
// - Device clears marker bit after use
// - Wait dummy pixel count before calibrating
// - Black pixel count bounds both stages
// - Coarse iteration is whole sample periods
// - Device computes rounded-up coarse iteration length
// - Register limits number of coarse iterations
// - Fine stage uses remaining black pixels
// - Test mode shows status on two LSBs
// - Software keeps gain fixed during calibration
// - Sequence-begin command clears itself
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module abc_device #(
   parameter int ACC_W = 22
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic clk_en,
   // Link
   abc_if.device     lnk
);
   abc_pkg::abc_state_t state;
   abc_pkg::abc_state_t next_state;
   logic        pin_q;
   logic [9:0]  pix_cnt;
   logic [2:0]  iter_cnt;
   logic [3:0]  iter_pix;
   logic [7:0]  dac;
   logic [ACC_W-1:0] acc [3];
   logic [9:0]  fine_n;
   logic [12:0] excess [3];
   logic [15:0] out_r;
   logic        valid_r;
   logic        taken_r;
   logic        seq_seen;

   // Bring a code to twelve-bit calibration scale
   function automatic logic [11:0] to12(input logic [15:0] c, input logic [1:0] res);
      case (res)
         abc_pkg::RES_16: to12 = c[15:4];
         abc_pkg::RES_12: to12 = c[11:0];
         abc_pkg::RES_10: to12 = {c[9:0], 2'h0};
         default:         to12 = {c[7:0], 4'h0};
      endcase
   endfunction

   // Target per channel, placed in the low byte of a twelve-bit code
   function automatic logic [11:0] tgt12(input logic [1:0] ch);
      case (ch)
         2'h0:    tgt12 = {4'h0, lnk.red_black_target};
         2'h1:    tgt12 = {4'h0, lnk.green_black_target};
         default: tgt12 = {4'h0, lnk.blue_black_target};
      endcase
   endfunction

   // Marker detection
   wire pin_mode   = lnk.line_marker_source[1];
   wire pin_rise   = lnk.output_enable_pin & ~pin_q;
   wire pin_fall   = ~lnk.output_enable_pin & pin_q;
   wire pin_edge   = lnk.line_marker_source[0] ? pin_fall : pin_rise;
   wire reg_mark   = lnk.line_marker_source == abc_pkg::MARK_REG &&
                     lnk.line_marker_bit && !taken_r;
   wire line_start = (pin_mode ? pin_edge : reg_mark) | (lnk.sequence_begin_cmd & ~seq_seen);

   // Coarse iteration length: minimum clocks over clocks per sample, rounded up
   wire [5:0] cmin = lnk.channel_count == 2'h3 ? abc_pkg::CMIN_THREE :
                     lnk.channel_count == 2'h2 ? abc_pkg::CMIN_TWO : abc_pkg::CMIN_MONO;
   wire [3:0] ratio = lnk.mclk_per_sample == 4'h0 ? 4'h1 : lnk.mclk_per_sample;
   wire [5:0] ceil_q = 6'((7'(cmin) + 7'(ratio) - 7'h1) / 7'(ratio));
   wire [3:0] iter_len = ceil_q[3:0] == 4'h0 ? 4'h1 : ceil_q[3:0];

   // Sample path
   wire        strobe   = lnk.pixel_sample_strobe;
   wire [1:0]  ch       = lnk.adc_channel == 2'h3 ? 2'h2 : lnk.adc_channel;
   wire [11:0] code12   = to12(lnk.adc_code, lnk.resolution);
   wire        pix_done = strobe && ch == 2'h2;
   wire        last_blk = pix_cnt == 10'h1;
   wire        coarse_end = iter_cnt >= lnk.coarse_iteration_limit;
   wire signed [13:0] err = $signed({2'h0, code12}) - $signed({2'h0, tgt12(ch)});
   wire signed [ACC_W-1:0] err_x = ACC_W'(err);  // Sign kept so mixed excesses average right
   wire signed [14:0] corr = $signed({3'h0, code12}) - $signed({excess[ch][12], excess[ch][12],
                                                                  excess[ch]});
   wire [11:0] sat12 = corr < 0 ? 12'h000 : corr > 15'sd4095 ? 12'hfff : corr[11:0];
   wire [15:0] scaled = lnk.resolution == abc_pkg::RES_16 ? {sat12, lnk.adc_code[3:0]} :
                        lnk.resolution == abc_pkg::RES_12 ? {4'h0, sat12} :
                        lnk.resolution == abc_pkg::RES_10 ? {6'h0, sat12[11:2]} :
                        {8'h0, sat12[11:4]};
   wire        busy     = state != abc_pkg::ST_IDLE && state != abc_pkg::ST_APPLY;
   wire [1:0]  status2  = {state == abc_pkg::ST_COARSE, state == abc_pkg::ST_FINE};
   wire [15:0] pass_out = state == abc_pkg::ST_APPLY ? scaled : lnk.adc_code;
   wire [15:0] next_out = lnk.calib_status_on_output ? {pass_out[15:2], status2} :
                          pass_out;

   // Next state
   always_comb begin
      next_state = state;
      case (state)
         abc_pkg::ST_IDLE, abc_pkg::ST_APPLY:
            if (line_start) next_state = abc_pkg::ST_DELAY;
         abc_pkg::ST_DELAY:
            if (pix_done && pix_cnt == 10'h0) next_state = abc_pkg::ST_COARSE;
         abc_pkg::ST_COARSE:
            if (lnk.black_pixel_count == 10'h0) next_state = abc_pkg::ST_APPLY;
            else if (pix_done && last_blk) next_state = abc_pkg::ST_APPLY;
            else if (pix_done && coarse_end) next_state = abc_pkg::ST_FINE;
         abc_pkg::ST_FINE:
            if (pix_done && last_blk) next_state = abc_pkg::ST_APPLY;
         default: next_state = abc_pkg::ST_IDLE;
      endcase
   end

   // Calibration engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state    <= abc_pkg::ST_IDLE;
         pin_q    <= 1'b0;
         pix_cnt  <= 10'h0;
         iter_cnt <= 3'h0;
         iter_pix <= 4'h0;
         dac      <= abc_pkg::DAC_RST;
         fine_n   <= 10'h0;
         taken_r  <= 1'b0;
         seq_seen <= 1'b0;
         for (int i = 0; i < 3; i++) begin
            acc[i]    <= '0;
            excess[i] <= 13'h0;
         end
      end else if (clk_en) begin
         state    <= next_state;
         pin_q    <= lnk.output_enable_pin;
         taken_r  <= reg_mark;
         seq_seen <= lnk.sequence_begin_cmd;
         if (line_start) begin
            pix_cnt  <= 10'(lnk.dummy_pixel_delay);
            iter_cnt <= 3'h0;
            iter_pix <= 4'h0;
            fine_n   <= 10'h0;
            for (int i = 0; i < 3; i++) acc[i] <= '0;
         end else if (pix_done) begin
            case (state)
               abc_pkg::ST_DELAY:
                  if (pix_cnt == 10'h0) pix_cnt <= lnk.black_pixel_count - 10'h1;
                  else pix_cnt <= pix_cnt - 10'h1;
               abc_pkg::ST_COARSE, abc_pkg::ST_FINE: pix_cnt <= pix_cnt - 10'h1;
               default: pix_cnt <= pix_cnt;
            endcase
         end else if (state == abc_pkg::ST_DELAY && strobe && pix_cnt == 10'h0) begin
            pix_cnt <= pix_cnt;
         end
         // Coarse loop: one DAC step per whole-pixel iteration
         if (state == abc_pkg::ST_COARSE && pix_done && !coarse_end) begin
            if (iter_pix + 4'h1 >= iter_len) begin
               iter_pix <= 4'h0;
               iter_cnt <= iter_cnt + 3'h1;
               if (err > 14'sd0 && dac != 8'h00) dac <= dac - 8'h01;
               else if (err < 14'sd0 && dac != 8'hff) dac <= dac + 8'h01;
            end else begin
               iter_pix <= iter_pix + 4'h1;
            end
         end
         // Fine loop: accumulate excess of each black code over its target
         if (state == abc_pkg::ST_FINE && strobe) begin
            acc[ch] <= acc[ch] + err_x;
            if (pix_done) fine_n <= fine_n + 10'h1;
         end
         if (state == abc_pkg::ST_FINE && next_state == abc_pkg::ST_APPLY) begin
            for (int i = 0; i < 3; i++)
               excess[i] <= 13'($signed(acc[i] + (i == ch ? err_x : '0)) /
                                $signed(ACC_W'(fine_n + 10'h1)));
         end
      end
   end

   // Output register: corrected codes in the apply state, raw codes otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_r   <= 16'h0;
         valid_r <= 1'b0;
      end else if (clk_en) begin
         valid_r <= strobe;
         if (strobe) out_r <= next_out;
      end
   end

   assign lnk.output_data_bus = out_r;
   assign lnk.output_valid    = valid_r;
   assign lnk.marker_taken    = taken_r;
   assign lnk.calib_busy      = busy;
   assign lnk.offset_dac      = dac;
endmodule

// file: sim/abc_monitor.sv
// Concurrent checks on the signals of the calibration link
`timescale 1ns/10ps
module abc_monitor (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // Link signals
   input wire logic [1:0] line_marker_source,
   input wire logic       line_marker_bit,
   input wire logic       sequence_begin_cmd,
   input wire logic       output_enable_pin,
   input wire logic       pixel_sample_strobe,
   input wire logic       output_valid,
   input wire logic       marker_taken,
   input wire logic       calib_busy,
   input wire logic [7:0] offset_dac
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Line start events for each marker source; pin edges count only while calib_busy is low
   sequence s_reg_mark;
      (line_marker_source == abc_pkg::MARK_REG) && $rose(line_marker_bit);
   endsequence
   sequence s_pin_rise;
      (line_marker_source == abc_pkg::MARK_PIN_POS) && $rose(output_enable_pin) && !calib_busy;
   endsequence
   sequence s_pin_fall;
      (line_marker_source == abc_pkg::MARK_PIN_NEG) && $fell(output_enable_pin) && !calib_busy;
   endsequence
   sequence s_wrong_edge;
      !calib_busy &&
      ((line_marker_source == abc_pkg::MARK_PIN_POS) && $fell(output_enable_pin) ||
       (line_marker_source == abc_pkg::MARK_PIN_NEG) && $rose(output_enable_pin));
   endsequence

   // Marker detection and hand-back
   reg_mark_a: assert property (s_reg_mark |=> marker_taken)
      else $error("register marker not taken on the next edge");
   mark_clear_a: assert property (
      (marker_taken && line_marker_source == abc_pkg::MARK_REG) |-> ##[0:2] !line_marker_bit)
      else $error("marker bit not cleared after use");
   pin_rise_a: assert property (s_pin_rise |=> calib_busy)
      else $error("rising pin marker not taken");
   pin_fall_a: assert property (s_pin_fall |=> calib_busy)
      else $error("falling pin marker not taken");
   pin_pol_a: assert property (s_wrong_edge |=> !calib_busy)
      else $error("line started on the wrong pin edge");
   busy_after_a: assert property (marker_taken |-> ##[0:1] calib_busy)
      else $error("calibration not started after marker");
   // Pixel output timing, offset stability and sequence command pulse
   valid_follow_a: assert property (pixel_sample_strobe |=> output_valid)
      else $error("no output one cycle after strobe");
   valid_quiet_a: assert property (!pixel_sample_strobe |=> !output_valid)
      else $error("output without a strobe");
   dac_hold_a: assert property ($changed(offset_dac) |-> $past(calib_busy))
      else $error("offset dac moved outside calibration");
   seq_pulse_a: assert property (sequence_begin_cmd |=> !sequence_begin_cmd)
      else $error("sequence begin command not self clearing");
endmodule

// file: sim/abc_tb.sv
// Self-checking bench for the controller and device pair
`timescale 1ns/10ps
module abc_tb;
   // Clock, reset and APB master
   logic        pclk    = 1'b0;
   logic        presetn = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rdat;
   logic        rerr;
   int          failures = 0;
   int          n_tests  = 0;

   always #4 pclk = ~pclk;

   // Both ends joined by the link, checker beside it
   abc_if link ();
   abc_host i_abc_host (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lnk(link.host));
   abc_device i_abc_device (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .lnk(link.device));
   abc_monitor i_abc_monitor (.pclk(pclk), .presetn(presetn),
      .line_marker_source(link.line_marker_source), .line_marker_bit(link.line_marker_bit),
      .sequence_begin_cmd(link.sequence_begin_cmd), .output_enable_pin(link.output_enable_pin),
      .pixel_sample_strobe(link.pixel_sample_strobe), .output_valid(link.output_valid),
      .marker_taken(link.marker_taken), .calib_busy(link.calib_busy),
      .offset_dac(link.offset_dac));

   // Verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One APB transfer: setup, then access until pready
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         report_and_stop();
      end
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask

   // Compare one word
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One sample of channel B, which also closes the pixel
   task automatic strobe(input logic [11:0] code);
      wr(abc_pkg::REG_CMD, {4'h0, code, 10'h0, 2'h2, 4'h8});
   endtask

   // Reset values, per-channel targets and an unmapped address
   task automatic t_regs();
      rd(abc_pkg::REG_RESULT);
      check("offset dac reset", {24'h0, abc_pkg::DAC_RST}, rdat);
      rd(abc_pkg::REG_TARGET);
      check("target reset", {8'h0, {3{abc_pkg::TARGET_RST}}}, rdat);
      wr(abc_pkg::REG_TARGET, 32'h00c0a040);
      rd(abc_pkg::REG_TARGET);
      check("targets", 32'h00c0a040, rdat);
      rd(8'h1c);
      check("unmapped error", 32'h1, {31'h0, rerr});
      check("unmapped data", 32'h0, rdat);
      $display("test registers done");
   endtask

   // One line: mark, dummy and black pixels, then one corrected image pixel
   task automatic t_line(input int how, input logic [11:0] blk, input logic [7:0] tgt,
                         input logic [11:0] img);
      logic [1:0]  src;
      logic [7:0]  dac0;
      int          o;
      src = (how < 2) ? abc_pkg::MARK_REG : 2'(how);
      o = int'(img) - (int'(blk) - int'(tgt));
      o = (o < 0) ? 0 : ((o > 4095) ? 4095 : o);
      rd(abc_pkg::REG_RESULT);
      dac0 = rdat[7:0];
      wr(abc_pkg::REG_CTRL, {20'h0, 4'h4, 4'h0, abc_pkg::RES_12, src});
      wr(abc_pkg::REG_TARGET, {8'h0, tgt, 8'h55, 8'haa});
      wr(abc_pkg::REG_TIMING, {5'h0, 3'h1, 6'h0, 10'd7, 1'b0, 7'd2});
      if (how == 0) wr(abc_pkg::REG_CMD, 32'h1);
      else if (how == 1) wr(abc_pkg::REG_CMD, 32'h2);
      else begin
         wr(abc_pkg::REG_CMD, 32'h4);
         wr(abc_pkg::REG_CMD, 32'h4);
         wr(abc_pkg::REG_CMD, 32'h0);
      end
      repeat (3 + 7 + 2) strobe(blk);
      rd(abc_pkg::REG_RESULT);
      n_tests++;
      if (rdat[7:0] === dac0) begin
         failures++;
         $display("MISMATCH offset dac expected change from %h seen %h", dac0, rdat[7:0]);
      end
      strobe(img);
      // The stored code lands two cycles after the strobe reaches the device
      repeat (2) @(posedge pclk);
      rd(abc_pkg::REG_PIXEL);
      check("corrected code", {20'h0, 12'(o)}, rdat);
      $display("test line with marker %0d done", how);
   endtask

   // Test mode: pixel 4 is the first coarse pixel, pixel 8 the first fine one
   task automatic t_status();
      wr(abc_pkg::REG_CTRL, {19'h0, 1'b1, 4'h4, 4'h0, abc_pkg::RES_12, abc_pkg::MARK_REG});
      wr(abc_pkg::REG_CMD, 32'h2);
      for (int k = 1; k <= 9; k++) begin
         strobe(12'h120);
         if (k == 4 || k == 8) begin
            repeat (2) @(posedge pclk);
            rd(abc_pkg::REG_PIXEL);
            check("status bits", (k == 4) ? 32'h122 : 32'h121, rdat);
         end
      end
      $display("test status output done");
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_line(0, 12'h120, 8'h20, 12'h300);
      t_line(2, 12'h120, 8'h20, 12'h050);
      t_line(3, 12'h010, 8'h80, 12'hff0);
      t_line(1, 12'h200, 8'h40, 12'h400);
      t_status();
      report_and_stop();
   end
endmodule
